// ===== design/hsp_pkg.sv
// Purpose: Shared constants and types of the host select and printer port block
// Assumes: One 200 MHz clock, synchronous active high reset
// Notes: Printer port offsets are two address bits wide
package hsp_pkg;

  // Printer port register offsets
  localparam logic [1:0] PP_DATA_OFS = 2'h0;
  localparam logic [1:0] PP_STAT_OFS = 2'h1;
  localparam logic [1:0] PP_CTRL_OFS = 2'h2;
  localparam logic [1:0] PP_IOSEL_OFS = 2'h3;

  // Control register fields
  localparam int CTRL_AUTOLF_BIT = 1;
  localparam int CTRL_IRQEN_BIT = 4;
  localparam int CTRL_DIR_BIT = 5;

  // Status register fields
  localparam int STAT_IRQ_BIT = 2;
  localparam int STAT_ACK_BIT = 6;
  localparam int STAT_BUSY_BIT = 7;

  // Direction patterns for the I/O select register
  localparam logic [7:0] IOSEL_IN_PAT = 8'hAA;
  localparam logic [7:0] IOSEL_OUT_PAT = 8'h55;

  // Values after reset
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic IOSEL_DIR_RST = 1'b0;

  // Access offered to one serial channel
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } hsp_chan_req_t;

  // Complete state of the top module
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic ack_n;
    logic [7:0] rdata;
    logic [7:0] pdata;
    logic [7:0] ctrl;
    logic iosel_in;
    logic irq_flag;
    hsp_chan_req_t chan_a;
    hsp_chan_req_t chan_b;
  } hsp_state_t;

endpackage

// ===== design/hsp_top.sv
// Purpose: Host select decode, printer port registers and printer pin control
// Assumes: All inputs synchronous to sys_clk; strobes last at least two cycles
// Notes: Serial channel register sets live outside; this block steers accesses
`timescale 1ns/1ps

module hsp_top
  import hsp_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 3,
  parameter bit IRQ_ACTIVE_HIGH = 1'b1
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Host bus
  input wire logic chan_a_sel_n,
  input wire logic chan_b_sel_n,
  input wire logic printer_sel_n,
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic [DATA_W-1:0] host_data_i,
  output logic [DATA_W-1:0] host_data_o,
  output logic host_data_oe_n,
  // Serial channel access
  output hsp_chan_req_t chan_a_req,
  output hsp_chan_req_t chan_b_req,
  input wire logic [DATA_W-1:0] chan_a_rdata,
  input wire logic [DATA_W-1:0] chan_b_rdata,
  // Printer pins
  input wire logic [DATA_W-1:0] printer_data_lines_i,
  output logic [DATA_W-1:0] printer_data_lines_o,
  output logic printer_data_lines_oe_n,
  input wire logic ack_n,
  input wire logic busy,
  input wire logic auto_line_feed_n_i,
  output logic auto_line_feed_n_o,
  output logic auto_line_feed_n_oe_n,
  input wire logic dir_source_sel,
  input wire logic printer_irq_latch_sel,
  output logic printer_irq
);

  // Elaboration checks
  if (DATA_W != 8) $error("hsp_top supports only an eight bit data bus");
  if (ADDR_W != 3) $error("hsp_top supports only three address bits");

  hsp_state_t st_q;
  hsp_state_t st_d;

  logic rd_fall;
  logic rd_rise;
  logic wr_fall;
  logic sel_a;
  logic sel_b;
  logic sel_p;
  logic dir_in;
  logic irq_active;
  logic [1:0] p_addr;

  // Strobe edges and unit decode
  assign rd_fall = st_q.rd_n & ~host_rd_n;
  assign rd_rise = ~st_q.rd_n & host_rd_n;
  assign wr_fall = st_q.wr_n & ~host_wr_n;
  assign sel_a = ~chan_a_sel_n;
  assign sel_b = ~chan_b_sel_n;
  assign sel_p = ~printer_sel_n;
  assign p_addr = host_addr[1:0];

  // Direction source
  assign dir_in = dir_source_sel ? st_q.ctrl[CTRL_DIR_BIT] : st_q.iosel_in;

  // Interrupt level before polarity
  assign irq_active = printer_irq_latch_sel ? st_q.irq_flag : ~ack_n;

  // Exclusive unit decode: own select low, both others high
  function automatic logic only_sel(input logic own_n, input logic oth1_n, input logic oth2_n);
    return !own_n && oth1_n && oth2_n;
  endfunction

  always_comb
  begin
    st_d = st_q;
    st_d.rd_n = host_rd_n;
    st_d.wr_n = host_wr_n;
    st_d.ack_n = ack_n;
    st_d.chan_a.rd = 1'b0;
    st_d.chan_a.wr = 1'b0;
    st_d.chan_b.rd = 1'b0;
    st_d.chan_b.wr = 1'b0;
    // Channel requests carry the bus address and byte unchanged
    st_d.chan_a.addr = host_addr;
    st_d.chan_b.addr = host_addr;
    st_d.chan_a.wdata = host_data_i;
    st_d.chan_b.wdata = host_data_i;
    if (only_sel(chan_a_sel_n, chan_b_sel_n, printer_sel_n))
    begin
      st_d.chan_a.rd = rd_fall;
      st_d.chan_a.wr = wr_fall;
    end
    if (only_sel(chan_b_sel_n, chan_a_sel_n, printer_sel_n))
    begin
      st_d.chan_b.rd = rd_fall;
      st_d.chan_b.wr = wr_fall;
    end
    // Printer register writes
    if (only_sel(printer_sel_n, chan_a_sel_n, chan_b_sel_n) && wr_fall)
    begin
      case (p_addr)
        PP_DATA_OFS:
          st_d.pdata = host_data_i;
        PP_CTRL_OFS:
          st_d.ctrl = host_data_i;
        PP_IOSEL_OFS:
        begin
          if (host_data_i == IOSEL_IN_PAT)
            st_d.iosel_in = 1'b1;
          else if (host_data_i == IOSEL_OUT_PAT)
            st_d.iosel_in = 1'b0;
        end
        default:
          st_d.iosel_in = st_q.iosel_in;
      endcase
    end
    // Read data capture on the falling read strobe
    if (rd_fall)
    begin
      if (sel_a)
        st_d.rdata = chan_a_rdata;
      else if (sel_b)
        st_d.rdata = chan_b_rdata;
      else if (sel_p)
      begin
        case (p_addr)
          PP_DATA_OFS:
            st_d.rdata = dir_in ? printer_data_lines_i : st_q.pdata;
          PP_STAT_OFS:
          begin
            st_d.rdata = 8'h00;
            st_d.rdata[STAT_BUSY_BIT] = busy;
            st_d.rdata[STAT_ACK_BIT] = ack_n;
            st_d.rdata[STAT_IRQ_BIT] = irq_active;
          end
          PP_CTRL_OFS:
            st_d.rdata = st_q.ctrl;
          default:
          begin
            st_d.rdata = st_q.ctrl;
            st_d.rdata[CTRL_DIR_BIT] = dir_in;
            st_d.rdata[CTRL_AUTOLF_BIT] = ~auto_line_feed_n_i;
          end
        endcase
      end
    end
    // Latched interrupt: cleared at end of printer read, a new edge wins
    if (sel_p && rd_rise)
      st_d.irq_flag = 1'b0;
    if (st_q.ack_n && !ack_n)
      st_d.irq_flag = 1'b1;
  end

  // Single clock for all state
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_q <= '0;
      st_q.rd_n <= 1'b1;
      st_q.wr_n <= 1'b1;
      st_q.ack_n <= 1'b1;
      st_q.pdata <= DATA_RST;
      st_q.ctrl <= CTRL_RST;
      st_q.iosel_in <= IOSEL_DIR_RST;
    end
    else
      st_q <= st_d;
  end

  // Host bus drive
  assign host_data_o = st_q.rdata;
  assign host_data_oe_n = ~(~host_rd_n & (sel_a | sel_b | sel_p));

  // Channel access outputs
  assign chan_a_req = st_q.chan_a;
  assign chan_b_req = st_q.chan_b;

  // Printer data lines
  assign printer_data_lines_o = st_q.pdata;
  assign printer_data_lines_oe_n = dir_in;

  // Auto line feed, open drain
  assign auto_line_feed_n_o = 1'b0;
  assign auto_line_feed_n_oe_n = ~st_q.ctrl[CTRL_AUTOLF_BIT];

  // Interrupt output, inactive while disabled
  always_comb
  begin
    if (!st_q.ctrl[CTRL_IRQEN_BIT])
      printer_irq = ~IRQ_ACTIVE_HIGH;
    else
      printer_irq = IRQ_ACTIVE_HIGH ? irq_active : ~irq_active;
  end

  // Checks
  a_bus_drive_sel: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !host_data_oe_n |-> (!host_rd_n && (!chan_a_sel_n || !chan_b_sel_n || !printer_sel_n)))
    else $error("Data bus driven outside a selected read");
  a_chan_a_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (chan_a_sel_n && $fell(host_wr_n)) |=> !chan_a_req.wr)
    else $error("Channel A written while deselected");
  a_chan_b_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!chan_b_sel_n && chan_a_sel_n && printer_sel_n && $fell(host_rd_n)) |=> chan_b_req.rd)
    else $error("Channel B read strobe missing");
  a_ctrl_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!printer_sel_n && chan_a_sel_n && chan_b_sel_n && $fell(host_wr_n)
      && host_addr[1:0] == PP_CTRL_OFS) |=> st_q.ctrl == $past(host_data_i))
    else $error("Control register not loaded");
  a_dir_bit_src: assert property (@(posedge sys_clk) disable iff (sys_rst)
    dir_source_sel |-> printer_data_lines_oe_n == st_q.ctrl[CTRL_DIR_BIT])
    else $error("Direction not from control bit");
  a_iosel_pattern: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!dir_source_sel && !printer_sel_n && chan_a_sel_n && chan_b_sel_n && $fell(host_wr_n)
      && host_addr[1:0] == PP_IOSEL_OFS && host_data_i == IOSEL_OUT_PAT)
      ##1 !dir_source_sel |-> !printer_data_lines_oe_n)
    else $error("Output pattern did not turn lines to output");
  a_irq_latch_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st_q.irq_flag && !(printer_sel_n == 1'b0 && $rose(host_rd_n)) && !$fell(ack_n))
      |=> st_q.irq_flag)
    else $error("Latched interrupt dropped without a read");
  a_irq_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!printer_irq_latch_sel && st_q.ctrl[CTRL_IRQEN_BIT])
      |-> printer_irq == (IRQ_ACTIVE_HIGH ? ~ack_n : ack_n))
    else $error("Interrupt does not follow acknowledge");
  a_autolf_drive: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_q.ctrl[CTRL_AUTOLF_BIT] |-> (!auto_line_feed_n_oe_n && !auto_line_feed_n_o))
    else $error("Auto line feed not pulled low");
  a_chan_a_rd_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (chan_a_sel_n && $fell(host_rd_n)) |=> !chan_a_req.rd)
    else $error("Channel A read while deselected");
  a_chan_a_strobe: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!chan_a_sel_n && chan_b_sel_n && printer_sel_n && $fell(host_wr_n)) |=> chan_a_req.wr)
    else $error("Channel A write strobe missing");
  a_chan_b_wr_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (chan_b_sel_n && $fell(host_wr_n)) |=> !chan_b_req.wr)
    else $error("Channel B written while deselected");
  a_multi_sel_block: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!chan_a_sel_n && !chan_b_sel_n)
      |=> !(chan_a_req.rd || chan_a_req.wr || chan_b_req.rd || chan_b_req.wr))
    else $error("Channel strobe with two selects low");
  a_pulse_single: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (chan_a_req.wr || chan_b_req.wr) |=> !(chan_a_req.wr || chan_b_req.wr))
    else $error("Channel write strobe longer than one cycle");
  a_chan_addr: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (chan_a_req.rd || chan_a_req.wr) |-> chan_a_req.addr == $past(host_addr))
    else $error("Channel A strobe with wrong address");
  a_chan_wdata: assert property (@(posedge sys_clk) disable iff (sys_rst)
    chan_b_req.wr |-> chan_b_req.wdata == $past(host_data_i))
    else $error("Channel B write data not the bus byte");
  a_rdata_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!chan_a_sel_n && $fell(host_rd_n)) |=> host_data_o == $past(chan_a_rdata))
    else $error("Channel A read data not captured");
  a_rdata_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (host_rd_n || !st_q.rd_n) |=> $stable(host_data_o))
    else $error("Read data changed without a read strobe");
  a_pdata_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!printer_sel_n && chan_a_sel_n && chan_b_sel_n && $fell(host_wr_n)
      && host_addr[1:0] == PP_DATA_OFS) |=> printer_data_lines_o == $past(host_data_i))
    else $error("Printer data register not loaded");
  a_dir_reg_src: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!dir_source_sel && !printer_sel_n && $fell(host_wr_n) && host_addr[1:0] == PP_CTRL_OFS)
      ##1 !dir_source_sel |-> $stable(printer_data_lines_oe_n))
    else $error("Control write moved direction under register control");
  a_iosel_in_pat: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!dir_source_sel && !printer_sel_n && chan_a_sel_n && chan_b_sel_n && $fell(host_wr_n)
      && host_addr[1:0] == PP_IOSEL_OFS && host_data_i == IOSEL_IN_PAT)
      ##1 !dir_source_sel |-> printer_data_lines_oe_n)
    else $error("Input pattern did not turn lines to input");
  a_irq_latch_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(ack_n) |=> st_q.irq_flag)
    else $error("Acknowledge edge did not latch the interrupt");
  a_irq_latch_pol: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (printer_irq_latch_sel && st_q.ctrl[CTRL_IRQEN_BIT] && st_q.irq_flag)
      |-> printer_irq == IRQ_ACTIVE_HIGH)
    else $error("Latched interrupt at wrong level");
  a_irq_disabled: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !st_q.ctrl[CTRL_IRQEN_BIT] |-> printer_irq == !IRQ_ACTIVE_HIGH)
    else $error("Disabled interrupt not at inactive level");
  a_autolf_release: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !st_q.ctrl[CTRL_AUTOLF_BIT] |-> auto_line_feed_n_oe_n)
    else $error("Auto line feed pulled while off");
  a_bus_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
    host_rd_n |-> host_data_oe_n)
    else $error("Data bus driven with read strobe high");

endmodule

// ===== sim/hsp_printer.sv
// Purpose: Printer model at the far side of the printer pins
// Assumes: Bench requests each byte accept
// Notes: Drives feed only while the port data lines are set to input, echoes pd_o otherwise
`timescale 1ns/1ps
module hsp_printer
(
  // Clock and bench control
  input wire logic sys_clk,
  input wire logic take,
  input wire logic [7:0] feed,
  // Printer pins
  input wire logic [7:0] pd_o,
  input wire logic pd_oe_n,
  output logic [7:0] pd_i,
  output logic ack_n,
  output logic busy
);
  int cnt = 0;
  assign pd_i = pd_oe_n ? feed : pd_o;
  always @(posedge sys_clk)
  begin
    if (take && cnt == 0)
      cnt <= 10;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
  assign busy = cnt != 0;
  assign ack_n = !(cnt inside {[2:3]});
endmodule

// ===== sim/test_host_select_and_printer_port_pins.sv
// Purpose: Self-checking bench of host select and printer port
// Assumes: Active low interrupt variant
// Notes: Random channel traffic with printer corner cases
`timescale 1ns/1ps
module test_host_select_and_printer_port_pins
  import hsp_pkg::*;
();
  localparam bit ACT = 1'b0;
  logic sys_clk = 0, sys_rst = 1, host_rd_n = 1, host_wr_n = 1;
  logic chan_a_sel_n = 1, chan_b_sel_n = 1, printer_sel_n = 1;
  logic [2:0] host_addr = 0;
  logic [7:0] host_data_i = 0, host_data_o, chan_a_rdata = 0, chan_b_rdata = 0;
  logic [7:0] pd_o, pd_i, feed = 0, q;
  logic host_data_oe_n, pd_oe_n, alf_o, alf_oe_n, alf_in, ack_n, busy, irq;
  logic dir_sel = 0, latch_sel = 0, take = 0;
  hsp_chan_req_t chan_a_req, chan_b_req, last_a, last_b;
  int n_errors = 0, cmp_count = 0, n_a = 0, n_b = 0;
  assign alf_in = alf_oe_n ? 1'b1 : alf_o;
  always #2.5 sys_clk = ~sys_clk;
  hsp_top #(.IRQ_ACTIVE_HIGH(ACT)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .chan_a_sel_n(chan_a_sel_n), .chan_b_sel_n(chan_b_sel_n),
    .printer_sel_n(printer_sel_n), .host_addr(host_addr), .host_rd_n(host_rd_n),
    .host_wr_n(host_wr_n), .host_data_i(host_data_i), .host_data_o(host_data_o),
    .host_data_oe_n(host_data_oe_n), .chan_a_req(chan_a_req),
    .chan_b_req(chan_b_req), .chan_a_rdata(chan_a_rdata),
    .chan_b_rdata(chan_b_rdata), .printer_data_lines_i(pd_i),
    .printer_data_lines_o(pd_o), .printer_data_lines_oe_n(pd_oe_n),
    .ack_n(ack_n), .busy(busy), .auto_line_feed_n_i(alf_in),
    .auto_line_feed_n_o(alf_o), .auto_line_feed_n_oe_n(alf_oe_n),
    .dir_source_sel(dir_sel), .printer_irq_latch_sel(latch_sel),
    .printer_irq(irq));
  hsp_printer prn (.sys_clk(sys_clk), .take(take), .feed(feed), .pd_o(pd_o),
    .pd_oe_n(pd_oe_n), .pd_i(pd_i), .ack_n(ack_n), .busy(busy));
  always @(posedge sys_clk)
  begin
    if (chan_a_req.rd === 1'b1 || chan_a_req.wr === 1'b1)
    begin
      n_a <= n_a + 1;
      last_a <= chan_a_req;
    end
    if (chan_b_req.rd === 1'b1 || chan_b_req.wr === 1'b1)
    begin
      n_b <= n_b + 1;
      last_b <= chan_b_req;
    end
  end
  task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    cmp_count++;
    if (s !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      n_errors++;
    end
  endtask
  task acc(input int u, input bit w, input logic [2:0] a, input logic [7:0] d,
    output logic [7:0] r);
    @(negedge sys_clk);
    chan_a_sel_n = !(u == 0 || u == 3);
    chan_b_sel_n = !(u == 1 || u == 3);
    printer_sel_n = u != 2;
    host_addr = a;
    host_data_i = d;
    host_rd_n = w;
    host_wr_n = !w;
    repeat (3) @(negedge sys_clk);
    chk("oe", 16'(w), 16'(host_data_oe_n));
    r = host_data_o;
    host_rd_n = 1;
    host_wr_n = 1;
    @(negedge sys_clk);
    chk("oe_idle", 16'h1, 16'(host_data_oe_n));
    {chan_a_sel_n, chan_b_sel_n, printer_sel_n} = 3'h7;
  endtask
  function automatic logic [4:0] exp_req(input bit w, input logic [2:0] a);
    return {~w, w, a};
  endfunction
  function automatic logic [7:0] exp_chan(input int u, input logic [7:0] ra, input logic [7:0] rb);
    return (u == 1) ? rb : ra;
  endfunction
  function automatic logic exp_irq(input bit on);
    return on ? ACT : !ACT;
  endfunction
  task summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task pulse();
    take = 1;
    @(negedge sys_clk);
    take = 0;
    repeat (20) if (ack_n !== 1'b0) @(negedge sys_clk);
  endtask
  initial
  begin
    #100000;
    n_errors++;
    summarize();
  end
  initial
  begin
    int u, pa, pb;
    bit w;
    logic [2:0] a;
    logic [7:0] d, e;
    void'($urandom(26636));
    repeat (12) @(negedge sys_clk);
    sys_rst = 0;
    acc(2, 0, PP_CTRL_OFS, 8'h00, q);
    chk("ctrl_rst", 16'(CTRL_RST), 16'(q));
    chk("alf_rst", 16'h1, 16'(alf_oe_n));
    acc(2, 1, PP_IOSEL_OFS, IOSEL_OUT_PAT, q);
    chk("pd_out", 16'h0, 16'(pd_oe_n));
    d = $urandom;
    feed = ~d;
    acc(2, 1, PP_DATA_OFS, d, q);
    chk("pd_o", 16'(d), 16'(pd_o));
    acc(2, 0, PP_DATA_OFS, 8'h00, q);
    chk("pd_rd", 16'(d), 16'(q));
    acc(2, 1, PP_IOSEL_OFS, IOSEL_IN_PAT, q);
    acc(2, 1, PP_IOSEL_OFS, 8'h12, q);
    chk("pd_in", 16'h1, 16'(pd_oe_n));
    acc(2, 0, PP_DATA_OFS, 8'h00, q);
    chk("pd_rd_in", 16'(feed), 16'(q));
    dir_sel = 1;
    acc(2, 1, PP_CTRL_OFS, 8'h12, q);
    chk("bit5_lo", 16'h0, 16'(pd_oe_n));
    chk("alf_wire", 16'h0, 16'(alf_in));
    acc(2, 1, PP_CTRL_OFS, 8'h32, q);
    chk("bit5_hi", 16'h1, 16'(pd_oe_n));
    acc(2, 0, PP_IOSEL_OFS, 8'h00, q);
    chk("iosel_rd", 16'h32, 16'(q));
    for (int i = 0; i < 25; i++)
    begin
      u = (i == 24) ? 3 : $urandom % 2;
      w = (i == 24) ? 1 : $urandom % 2;
      a = $urandom;
      d = $urandom;
      chan_a_rdata = $urandom;
      chan_b_rdata = $urandom;
      e = exp_chan(u, chan_a_rdata, chan_b_rdata);
      pa = n_a;
      pb = n_b;
      acc(u, w, a, d, q);
      chk("a_cnt", 16'(pa + (u == 0)), 16'(n_a));
      chk("b_cnt", 16'(pb + (u == 1)), 16'(n_b));
      if (u == 3)
        continue;
      chk("req", 16'(exp_req(w, a)), 16'(u ? last_b[12:8] : last_a[12:8]));
      if (w)
        chk("wdata", 16'(d), 16'(u ? last_b.wdata : last_a.wdata));
      else
        chk("rdata", 16'(e), 16'(q));
    end
    take = 1;
    @(negedge sys_clk);
    take = 0;
    acc(2, 0, PP_STAT_OFS, 8'h00, q);
    chk("busy_bit", 16'h1, 16'(q[STAT_BUSY_BIT]));
    repeat (20) if (ack_n !== 1'b0) @(negedge sys_clk);
    chk("irq_follow", 16'(exp_irq(1)), 16'(irq));
    repeat (20) if (busy !== 1'b0) @(negedge sys_clk);
    chk("irq_idle", 16'(exp_irq(0)), 16'(irq));
    latch_sel = 1;
    acc(2, 0, PP_STAT_OFS, 8'h00, q);
    chk("irq_pre", 16'(exp_irq(0)), 16'(irq));
    pulse();
    repeat (20) if (busy !== 1'b0) @(negedge sys_clk);
    chk("irq_latch", 16'(exp_irq(1)), 16'(irq));
    acc(2, 0, PP_STAT_OFS, 8'h00, q);
    chk("irq_stat", 16'h1, 16'(q[STAT_IRQ_BIT]));
    chk("irq_clear", 16'(exp_irq(0)), 16'(irq));
    dir_sel = 0;
    acc(2, 1, PP_CTRL_OFS, 8'h00, q);
    chk("ctrl_no_dir", 16'h1, 16'(pd_oe_n));
    sys_rst = 1;
    repeat (2) @(negedge sys_clk);
    sys_rst = 0;
    chk("rst_dir", 16'(IOSEL_DIR_RST), 16'(pd_oe_n));
    chk("rst_irq", 16'(exp_irq(0)), 16'(irq));
    acc(2, 0, PP_DATA_OFS, 8'h00, q);
    chk("rst_data", 16'(DATA_RST), 16'(q));
    summarize();
  end
endmodule
